// >>> hw/reset_cause_and_power_down.sv
`timescale 1ns/1ps
module reset_cause_and_power_down
  import reset_pd_pkg::*;
(
  input  wire logic          sys_clk_in,               // 40 MHz clock
  input  wire logic          rst_b_in,                 // async power-on reset, low
  input  wire logic          psel_in,                  // apb select
  input  wire logic          penable_in,               // apb enable
  input  wire logic          pwrite_in,                // apb write
  input  wire logic [7:0]    paddr_in,                 // apb byte address
  input  wire logic [31:0]   pwdata_in,                // apb write data
  output logic      [31:0]   prdata_out,               // apb read data
  output logic               pready_out,               // apb ready
  output logic               pslverr_out,              // apb error, unmapped
  input  wire reset_events_t events_in,                // reset event strobes
  input  wire logic          fabric_reset_request_in,  // fabric asks system reset
  input  wire logic          interrupt_in,             // any interrupt, wakes
  input  wire logic          slow_crystal_in,          // low-frequency crystal
  output logic               alt_clock_out,            // fabric alternate clock
  output logic               system_reset_indication_n_out, // system reset, low
  output logic               processor_reset_out,      // processor reset, high
  output logic               config_reset_out,         // configuration reset, high
  output logic               pin_reset_disable_out,    // test-only pin disable
  output logic               power_down_out,           // power-down active
  output logic               clock_from_ring_osc_out,  // force ring oscillator
  output power_gates_t       gates_out                 // items turned off
);

  logic [2:0]             reset_control;
  logic [pd_width-1:0]    power_control;
  logic [cause_width-1:0] cause;
  logic [3:0]             sysrst_count;
  logic                   ring_osc_hold;
  logic                   power_on_seen;

  logic wr_en;
  logic rd_en;
  logic config_event;
  logic system_event;
  logic processor_event;
  logic soft_trigger;
  logic fabric_event;
  logic [cause_width-1:0] set_mask;
  logic [cause_width-1:0] clr_mask;

  function automatic logic hit(input logic [7:0] a);
    hit = (a == addr_reset_control) || (a == addr_power_down_control) ||
          (a == addr_reset_cause_status) || (a == addr_reset_cause_clear);
  endfunction

  assign wr_en       = psel_in && penable_in && pwrite_in && hit(paddr_in);
  assign rd_en       = psel_in && !pwrite_in;
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in && penable_in && !hit(paddr_in);

  assign soft_trigger = wr_en && paddr_in == addr_reset_control
                        && pwdata_in[software_system_reset_trigger];
  assign fabric_event = events_in.fabric || fabric_reset_request_in;
  // configuration resets cascade downward
  assign config_event    = events_in.external_pin || events_in.debug_config;
  assign system_event    = config_event || soft_trigger || fabric_event
                           || events_in.watchdog || events_in.debug_system;
  assign processor_event = system_event || events_in.debug_processor;

  always_comb
  begin
    set_mask = '0;
    set_mask[flag_software_reset]          = soft_trigger;
    set_mask[flag_debug_port_system_reset] = events_in.debug_system;
    set_mask[flag_any_system_reset]        = system_event;
    set_mask[flag_fabric_reset]            = fabric_event;
    set_mask[flag_watchdog_reset]          = events_in.watchdog;
    set_mask[flag_debug_processor_reset]   = events_in.debug_processor;
    set_mask[flag_any_processor_reset]     = processor_event;
    set_mask[flag_debug_config_reset]      = events_in.debug_config;
    set_mask[flag_external_pin]            = events_in.external_pin;
    set_mask[flag_any_config_reset]        = config_event;
    set_mask[flag_power_on]                = events_in.power_on || power_on_seen;
  end

  assign clr_mask = (wr_en && paddr_in == addr_reset_cause_clear)
                    ? pwdata_in[cause_width-1:0] : '0;

  // power-on capture: flags after asynchronous power-on reset
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      power_on_seen <= 1'b1;
    else
      power_on_seen <= 1'b0;
  end

  // sticky cause flags; set wins over clear
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cause <= cause_power_on_value;
    else
      cause <= (cause & ~clr_mask) | set_mask;
  end

  // reset control; trigger bit self-clears
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      reset_control <= reset_control_reset;
    else if (config_event)
      reset_control <= reset_control_reset;
    else if (wr_en && paddr_in == addr_reset_control)
      reset_control <= {1'b0, pwdata_in[secondary_pin_reset_disable], 1'b0};
  end

  // power control; interrupt clears the request, system reset clears all
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      power_control <= power_down_reset;
    else if (system_event)
      power_control <= power_down_reset;
    else if (interrupt_in)
      power_control[pd_request] <= 1'b0;
    else if (wr_en && paddr_in == addr_power_down_control)
      power_control <= pwdata_in[pd_width-1:0];
  end

  // after wake, system clock stays on the ring oscillator until software rewrites
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      ring_osc_hold <= 1'b0;
    else if (power_control[pd_request] && interrupt_in)
      ring_osc_hold <= 1'b1;
    else if (wr_en && paddr_in == addr_reset_control)
      ring_osc_hold <= 1'b0;
  end

  // system reset pulse
  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sysrst_count <= system_reset_cycles;
    else if (system_event)
      sysrst_count <= system_reset_cycles;
    else if (sysrst_count != 4'h0)
      sysrst_count <= sysrst_count - 4'h1;
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      system_reset_indication_n_out <= 1'b0;
    else
      system_reset_indication_n_out <= !(system_event || sysrst_count > 4'h1);
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      processor_reset_out <= 1'b1;
      config_reset_out    <= 1'b1;
    end
    else
    begin
      processor_reset_out <= processor_event;
      config_reset_out    <= config_event;
    end
  end

  // interrupt drops power-down combinationally, ahead of the clocked clear of the request bit
  assign power_down_out          = power_control[pd_request] && !interrupt_in;
  assign pin_reset_disable_out   = reset_control[secondary_pin_reset_disable];
  assign clock_from_ring_osc_out = ring_osc_hold;
  assign alt_clock_out           = slow_crystal_in;

  always_comb
  begin
    gates_out.ring_osc_off     = power_down_out && power_control[pd_osc_select];
    gates_out.io_off           = power_down_out && power_control[pd_io_select];
    gates_out.system_clock_off = power_down_out && power_control[pd_system_clock];
    gates_out.fabric_clock_off = power_down_out && power_control[pd_fabric_clock];
    gates_out.por_off          = power_control[pd_por_disable];
  end

  always_ff @(posedge sys_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      prdata_out <= 32'h0;
    else if (rd_en && !penable_in)
    begin
      unique case (paddr_in)
        addr_reset_control:      prdata_out <= {29'h0, reset_control};
        addr_power_down_control: prdata_out <= {26'h0, power_control};
        addr_reset_cause_status: prdata_out <= {21'h0, cause};
        default:                 prdata_out <= 32'h0;
      endcase
    end
  end

endmodule

// >>> common/reset_pd_pkg.sv
package reset_pd_pkg;

  // register byte addresses, one aligned word each
  localparam logic [7:0] addr_reset_control      = 8'h0c;
  localparam logic [7:0] addr_power_down_control = 8'h10;
  localparam logic [7:0] addr_reset_cause_status = 8'h30;
  localparam logic [7:0] addr_reset_cause_clear  = 8'h34;

  // reset control fields
  localparam int software_system_reset_trigger = 2;
  localparam int secondary_pin_reset_disable   = 1;

  // reset cause flag positions
  localparam int flag_software_reset          = 10;
  localparam int flag_debug_port_system_reset = 9;
  localparam int flag_any_system_reset        = 8;
  localparam int flag_fabric_reset            = 7;
  localparam int flag_watchdog_reset          = 6;
  localparam int flag_debug_processor_reset   = 5;
  localparam int flag_any_processor_reset     = 4;
  localparam int flag_debug_config_reset      = 3;
  localparam int flag_external_pin            = 2;
  localparam int flag_any_config_reset        = 1;
  localparam int flag_power_on                = 0;
  localparam int cause_width                  = 11;

  // power down control fields
  localparam int pd_por_disable  = 5;
  localparam int pd_request      = 4;
  localparam int pd_io_select    = 3;
  localparam int pd_osc_select   = 2;
  localparam int pd_fabric_clock = 1;
  localparam int pd_system_clock = 0;
  localparam int pd_width        = 6;

  localparam logic [2:0]             reset_control_reset  = 3'h0;
  localparam logic [pd_width-1:0]    power_down_reset     = 6'h00;
  localparam logic [cause_width-1:0] cause_power_on_value = 11'h001;

  // length of the generated system reset pulse, in clock cycles
  localparam logic [3:0] system_reset_cycles = 4'h4;

  typedef struct packed {
    logic power_on;
    logic external_pin;
    logic debug_config;
    logic debug_system;
    logic debug_processor;
    logic watchdog;
    logic fabric;
  } reset_events_t;

  typedef struct packed {
    logic ring_osc_off;
    logic io_off;
    logic system_clock_off;
    logic fabric_clock_off;
    logic por_off;
  } power_gates_t;

endpackage

// >>> verification/reset_cause_and_power_down_props.sv
`timescale 1ns/1ps
module reset_cause_and_power_down_props
  import reset_pd_pkg::*;
(
  input wire logic          sys_clk_in,
  input wire logic          rst_b_in,
  input wire logic          psel_in,
  input wire logic          penable_in,
  input wire logic          pwrite_in,
  input wire logic [7:0]    paddr_in,
  input wire logic [31:0]   pwdata_in,
  input wire reset_events_t events_in,
  input wire logic          fabric_reset_request_in,
  input wire logic          interrupt_in,
  input wire logic          slow_crystal_in,
  input wire logic          alt_clock_out,
  input wire logic          system_reset_indication_n_out,
  input wire logic          processor_reset_out,
  input wire logic          config_reset_out,
  input wire logic          pin_reset_disable_out,
  input wire logic          power_down_out,
  input wire logic          clock_from_ring_osc_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_b_in);
  wire wr = psel_in && penable_in && pwrite_in;
  property p_alt; alt_clock_out == slow_crystal_in; endproperty
  a_alt: assert property (p_alt) else $error("alt clock differs");
  property p_wake; interrupt_in |=> !power_down_out; endproperty
  a_wake: assert property (p_wake) else $error("power down during interrupt");
  property p_swr; wr && paddr_in == addr_reset_control && pwdata_in[2]
    |-> ##[1:2] !system_reset_indication_n_out; endproperty
  a_swr: assert property (p_swr) else $error("no soft system reset");
  property p_fab; fabric_reset_request_in |-> ##[1:2] !system_reset_indication_n_out; endproperty
  a_fab: assert property (p_fab) else $error("no fabric system reset");
  property p_cfg; events_in.external_pin |=> config_reset_out && processor_reset_out; endproperty
  a_cfg: assert property (p_cfg) else $error("config reset not spread");
  property p_ctl; events_in.debug_config |=> !pin_reset_disable_out; endproperty
  a_ctl: assert property (p_ctl) else $error("control kept after config reset");
  property p_pd; wr && paddr_in == addr_power_down_control && pwdata_in[4] && events_in == '0
    && !fabric_reset_request_in |=> power_down_out || interrupt_in; endproperty
  a_pd: assert property (p_pd) else $error("power down not entered");
  property p_ring; $rose(interrupt_in) && $past(power_down_out)
    |-> ##[1:2] clock_from_ring_osc_out; endproperty
  a_ring: assert property (p_ring) else $error("wake not on ring oscillator");
endmodule
bind reset_cause_and_power_down reset_cause_and_power_down_props u_props (.*);

// >>> verification/fabric_model.sv
`timescale 1ns/1ps
module fabric_model (
  input  wire logic clk_in,            // system clock
  input  wire logic sys_rst_n_in,      // system reset indication
  input  wire logic alt_clock_in,      // alternate clock from device
  input  wire logic reset_cmd_in,      // ask for a system reset
  input  wire logic wake_cmd_in,       // arm the wake counter
  output logic      slow_crystal_out,  // slow oscillator
  output logic      reset_request_out, // application reset request
  output logic      interrupt_out      // wake interrupt
);
  logic [2:0] div = 3'h0;
  logic [1:0] ticks = 2'h0;
  logic       alt_q = 1'b0;
  initial slow_crystal_out = 1'b0;
  initial reset_request_out = 1'b0;
  initial interrupt_out = 1'b0;
  always @(posedge clk_in)
  begin
    div <= div + 3'h1;
    slow_crystal_out <= div[2];
    alt_q <= alt_clock_in;
    if (!wake_cmd_in)
      ticks <= 2'h0;
    else if (alt_clock_in && !alt_q)
      ticks <= ticks + 2'h1;
    interrupt_out <= wake_cmd_in && ticks == 2'h3;
    if (!sys_rst_n_in)
      reset_request_out <= 1'b0;
    else if (reset_cmd_in)
      reset_request_out <= 1'b1;
  end
endmodule

// >>> verification/reset_cause_and_power_down_tb.sv
`timescale 1ns/1ps
module reset_cause_and_power_down_tb;
  import reset_pd_pkg::*;
  logic clk = 0, rst_b = 0, psel = 0, pen = 0, pwr = 0, rcmd = 0, wcmd = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, frq, irq, xtal, alt, ind_n, pdis, pd, ring;
  reset_events_t ev = '0;
  power_gates_t gates;
  int num_errors = 0, comparisons = 0, cycles = 0;
  always #12.5 clk = ~clk;
  reset_cause_and_power_down dut (.sys_clk_in(clk), .rst_b_in(rst_b), .psel_in(psel),
    .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr), .events_in(ev),
    .fabric_reset_request_in(frq), .interrupt_in(irq), .slow_crystal_in(xtal),
    .alt_clock_out(alt), .system_reset_indication_n_out(ind_n), .processor_reset_out(),
    .config_reset_out(), .pin_reset_disable_out(pdis), .power_down_out(pd),
    .clock_from_ring_osc_out(ring), .gates_out(gates));
  fabric_model partner (.clk_in(clk), .sys_rst_n_in(ind_n), .alt_clock_in(alt),
    .reset_cmd_in(rcmd), .wake_cmd_in(wcmd), .slow_crystal_out(xtal),
    .reset_request_out(frq), .interrupt_out(irq));
  task automatic end_sim;
    if (num_errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask
  task automatic t_reset;
    rdc("cause", addr_reset_cause_status, 32'h1);
    rdc("control", addr_reset_control, 32'h0);
    apb(1'b1, addr_reset_cause_clear, 32'h1);
    rdc("cause", addr_reset_cause_status, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped error", {31'h0, err}, 32'h1);
  endtask
  task automatic t_soft;
    apb(1'b1, addr_reset_control, 32'h4);
    rdc("control", addr_reset_control, 32'h0);
    rdc("cause", addr_reset_cause_status, 32'h510);
    apb(1'b1, addr_reset_cause_status, 32'h0);
    apb(1'b1, addr_reset_cause_clear, 32'h0);
    rdc("cause", addr_reset_cause_status, 32'h510);
    apb(1'b1, addr_reset_cause_clear, 32'h7ff);
  endtask
  task automatic t_events;
    logic [31:0] exp [6] = '{32'h190, 32'h150, 32'h030, 32'h310, 32'h11a, 32'h116};
    for (int i = 0; i < 6; i++)
    begin
      ev <= 7'h1 << i;
      @(posedge clk) ev <= '0;
      repeat (6) @(posedge clk);
      rdc("cause", addr_reset_cause_status, exp[i]);
      apb(1'b1, addr_reset_cause_clear, 32'h7ff);
    end
  endtask
  task automatic t_race;
    fork
      apb(1'b1, addr_reset_cause_clear, 32'h7ff);
      begin
        @(posedge clk) ev <= 7'h02;
        @(posedge clk) ev <= '0;
      end
    join
    repeat (6) @(posedge clk);
    rdc("cause", addr_reset_cause_status, 32'h150);
    apb(1'b1, addr_reset_cause_clear, 32'h7ff);
    rcmd <= 1'b1;
    @(posedge clk) rcmd <= 1'b0;
    repeat (8) @(posedge clk);
    rdc("cause", addr_reset_cause_status, 32'h190);
    apb(1'b1, addr_reset_cause_clear, 32'h7ff);
  endtask
  task automatic t_pd;
    apb(1'b1, addr_power_down_control, 32'h1f);
    check("power down", {31'h0, pd}, 32'h1);
    check("gates", {27'h0, gates}, 32'h1e);
    wcmd <= 1'b1;
    for (int n = 0; n < 64 && pd === 1'b1; n++) @(posedge clk);
    wcmd <= 1'b0;
    @(posedge clk);
    check("ring clock", {31'h0, ring}, 32'h1);
    check("gates", {27'h0, gates}, 32'h0);
    rdc("power control", addr_power_down_control, 32'h0f);
    apb(1'b1, addr_reset_control, 32'h0);
    check("ring clock", {31'h0, ring}, 32'h0);
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      end_sim;
    end
  end
  initial
  begin
    repeat (20) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_soft;
    t_events;
    t_race;
    t_pd;
    end_sim;
  end
endmodule
